// [rtl/rise_qualifier_regs.vh]
`ifndef RISE_QUALIFIER_REGS_VH
`define RISE_QUALIFIER_REGS_VH
// register indices (byte offsets on the plain port)
`define RQ_ADDR_ENABLE_LOW   4'h0
`define RQ_ADDR_ENABLE_HIGH  4'h1
`define RQ_ADDR_MODE_LOW     4'h2
`define RQ_ADDR_MODE_HIGH    4'h3
`define RQ_ADDR_PHASE_DELAY  4'h4
`define RQ_ADDR_STATUS       4'h5
// field layout
`define RQ_LOW_BITS          8
`define RQ_HIGH_BITS         6
`define RQ_SOURCES           14
`define RQ_HIGH_MASK         8'h3f
// reset values
`define RQ_RESET_ENABLE      8'h00
`define RQ_RESET_MODE        8'h00
`define RQ_RESET_DELAY       8'h00
`endif

// [rtl/rise_phase_delay.v]
`timescale 1ns/10ps
module rise_phase_delay #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             nrst,
  // control
  input  wire             start,
  input  wire [WIDTH-1:0] delayCount,
  // result
  output reg              done,
  output reg              busy
);

  reg [WIDTH-1:0] count_r;

  // counts delayCount cycles after start, then pulses done
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= {WIDTH{1'b0}};
      done    <= 1'b0;
      busy    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        if (delayCount == {WIDTH{1'b0}}) begin
          done <= 1'b1;
        end else begin
          count_r <= delayCount;
          busy    <= 1'b1;
        end
      end else if (busy) begin
        if (count_r == {{(WIDTH-1){1'b0}}, 1'b1}) begin
          done <= 1'b1;
          busy <= 1'b0;
        end
        count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // rise_phase_delay

// [rtl/rise_event_qualifier.v]
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "rise_qualifier_regs.vh"
module rise_event_qualifier #(
  parameter DELAY_WIDTH = 8
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        nrst,
  // register port
  input  wire [3:0]  addr,
  input  wire [7:0]  wrData,
  input  wire        wrStrobe,
  input  wire        rdStrobe,
  output reg  [7:0]  rdData,
  // sources: pin, cmp1-4, capture1-2, pwm3-6, logic cells 1-3
  input  wire        srcPin,
  input  wire [3:0]  srcComparator,
  input  wire [1:0]  srcCapture,
  input  wire [3:0]  srcPwm,
  input  wire [2:0]  srcLogicCell,
  // events
  output reg         riseEvent,
  output reg         riseImmediate,
  output reg         riseDelayed
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg  [7:0]             enableLow_r;
  reg  [5:0]             enableHigh_r;
  reg  [7:0]             modeLow_r;
  reg  [5:0]             modeHigh_r;
  reg  [DELAY_WIDTH-1:0] phaseDelay_r;
  reg  [13:0]            srcPrev_r;
  reg                    pendingEdge_r;
  wire [13:0]            srcNow;
  wire [13:0]            enableAll;
  wire [13:0]            modeAll;
  wire [13:0]            edgeReq;
  wire [13:0]            levelReq;
  wire                   anyEdge;
  wire                   anyLevel;
  wire                   delayDone;
  wire                   delayBusy;

  // source order: pin, cmp1-4, cap1-2, pwm3 low; pwm4-6, cells high
  assign srcNow    = {srcLogicCell, srcPwm, srcCapture, srcComparator, srcPin};
  assign enableAll = {enableHigh_r, enableLow_r};
  assign modeAll   = {modeHigh_r, modeLow_r};

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      enableLow_r  <= `RQ_RESET_ENABLE;
      enableHigh_r <= 6'h00;
      modeLow_r    <= `RQ_RESET_MODE;
      modeHigh_r   <= 6'h00;
      phaseDelay_r <= {DELAY_WIDTH{1'b0}};
    end else if (wrStrobe) begin
      case (addr)
        `RQ_ADDR_ENABLE_LOW:  enableLow_r  <= wrData;
        `RQ_ADDR_ENABLE_HIGH: enableHigh_r <= wrData[5:0];
        `RQ_ADDR_MODE_LOW:    modeLow_r    <= wrData;
        `RQ_ADDR_MODE_HIGH:   modeHigh_r   <= wrData[5:0];
        `RQ_ADDR_PHASE_DELAY: phaseDelay_r <= wrData[DELAY_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= 8'h00;
    end else if (rdStrobe) begin
      case (addr)
        `RQ_ADDR_ENABLE_LOW:  rdData <= enableLow_r;
        `RQ_ADDR_ENABLE_HIGH: rdData <= {2'b00, enableHigh_r};
        `RQ_ADDR_MODE_LOW:    rdData <= modeLow_r;
        `RQ_ADDR_MODE_HIGH:   rdData <= {2'b00, modeHigh_r};
        `RQ_ADDR_PHASE_DELAY: rdData <= phaseDelay_r;
        `RQ_ADDR_STATUS:      rdData <= {4'h0, pendingEdge_r, delayBusy, riseEvent, anyLevel};
        default:              rdData <= 8'h00;
      endcase
    end else begin
      rdData <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // qualification

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      srcPrev_r <= 14'h0000;
    end else begin
      srcPrev_r <= srcNow;
    end
  end

  assign edgeReq  = enableAll & modeAll & srcNow & ~srcPrev_r;
  assign levelReq = enableAll & ~modeAll & srcNow;
  assign anyEdge  = |edgeReq;
  assign anyLevel = |levelReq;

  // edge arriving while delay runs is held and started afterwards
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pendingEdge_r <= 1'b0;
    end else if (anyEdge && delayBusy) begin
      pendingEdge_r <= 1'b1;
    end else if (!delayBusy) begin
      pendingEdge_r <= 1'b0;
    end
  end

  rise_phase_delay #(
    .WIDTH (DELAY_WIDTH)
  ) u_delay (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .start      (anyEdge | pendingEdge_r),
    .delayCount (phaseDelay_r),
    .done       (delayDone),
    .busy       (delayBusy)
  );

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      riseEvent     <= 1'b0;
      riseImmediate <= 1'b0;
      riseDelayed   <= 1'b0;
    end else begin
      riseImmediate <= anyLevel;
      riseDelayed   <= delayDone;
      riseEvent     <= anyLevel | delayDone;
    end
  end

endmodule // rise_event_qualifier

// [tb/rise_src_model.sv]
`timescale 1ns/10ps
module rise_src_model (
  // clock and request
  input  wire        core_clk,
  input  wire [13:0] want,
  // sources
  output reg  [13:0] srcVec
);
  always @(posedge core_clk) begin
    srcVec <= want;
  end
endmodule // rise_src_model

// [tb/rise_event_qualifier_sva.sv]
`timescale 1ns/10ps
module rise_event_qualifier_sva (
  // clock, reset, port
  input wire       core_clk,
  input wire       nrst,
  input wire [3:0] addr,
  input wire       rdStrobe,
  input wire [7:0] rdData,
  // sources
  input wire       srcPin,
  input wire [3:0] srcComparator,
  input wire [1:0] srcCapture,
  input wire [3:0] srcPwm,
  input wire [2:0] srcLogicCell,
  // events
  input wire       riseEvent,
  input wire       riseImmediate,
  input wire       riseDelayed
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire anySrc = srcPin | (|srcComparator) | (|srcCapture) | (|srcPwm) | (|srcLogicCell);
  a_read_idle: assert property (!$past(rdStrobe) |-> rdData == 8'h00) else $error("rd idle");
  a_upper_zero: assert property (rdStrobe && (addr == 4'h1 || addr == 4'h3) |=> rdData[7:6] == 2'h0)
    else $error("upper bits");
  a_unmapped_zero: assert property (rdStrobe && addr > 4'h5 |=> rdData == 8'h00) else $error("unmapped");
  a_imm_event: assert property (riseImmediate |-> riseEvent) else $error("imm");
  a_dly_event: assert property (riseDelayed |-> riseEvent) else $error("dly");
  a_event_cause: assert property (riseEvent |-> riseImmediate || riseDelayed) else $error("cause");
  a_imm_source: assert property (riseImmediate |-> $past(anySrc)) else $error("imm src");
  a_reset_quiet: assert property ($rose(nrst) |-> !riseEvent && !riseDelayed) else $error("rst");
  c_imm: cover property (riseImmediate);
  c_dly: cover property (riseDelayed);
  c_rd: cover property (rdStrobe && addr == 4'h1);
endmodule // rise_event_qualifier_sva
bind rise_event_qualifier rise_event_qualifier_sva chk_u (.core_clk, .nrst, .addr, .rdStrobe, .rdData, .srcPin,
  .srcComparator, .srcCapture, .srcPwm, .srcLogicCell, .riseEvent, .riseImmediate, .riseDelayed);

// [tb/rise_event_qualifier_bench.sv]
`timescale 1ns/10ps
module rise_event_qualifier_bench;
  reg         core_clk = 1'b0;
  reg         nrst = 1'b0;
  reg  [3:0]  addr = 4'h0;
  reg  [7:0]  wrData = 8'h00;
  reg         wrStrobe = 1'b0;
  reg         rdStrobe = 1'b0;
  reg  [13:0] want = 14'h0000;
  reg  [7:0]  c0, c1, d;
  wire [13:0] srcVec;
  wire [7:0]  rdData;
  wire        riseEvent, riseImmediate, riseDelayed;
  integer     err_total = 0;
  integer     comparisons = 0;
  integer     cycles = 0;
  integer     i;
  always #50 core_clk = ~core_clk;
  rise_src_model src_u (.core_clk(core_clk), .want(want), .srcVec(srcVec));
  rise_event_qualifier dut_u (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .srcPin(srcVec[0]), .srcComparator(srcVec[4:1]), .srcCapture(srcVec[6:5]),
    .srcPwm(srcVec[10:7]), .srcLogicCell(srcVec[13:11]), .riseEvent(riseEvent), .riseImmediate(riseImmediate),
    .riseDelayed(riseDelayed));
  ////////////////////////////////////////////////////////////////
  task final_report;
    begin
      if (err_total == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [47:0] nm, input [7:0] e, input [7:0] s);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    begin
      addr <= a;
      wrData <= v;
      wrStrobe <= 1'b1;
      @(posedge core_clk);
      wrStrobe <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge core_clk);
      rdStrobe <= 1'b0;
      #1 chk("rdData", e, rdData);
      @(posedge core_clk);
    end
  endtask
  task cfg(input [13:0] en, input [13:0] md);
    begin
      wr(4'h0, en[7:0]);
      wr(4'h1, {2'h0, en[13:8]});
      wr(4'h2, md[7:0]);
      wr(4'h3, {2'h0, md[13:8]});
    end
  endtask
  task idle;
    begin
      repeat (4) @(posedge core_clk);
      #1;
    end
  endtask
  task cnt(input dly, output [7:0] c);
    begin
      c = 8'h00;
      while ((dly ? riseDelayed : riseImmediate) !== 1'b1 && c < 8'h28) begin
        @(posedge core_clk);
        #1 c = c + 8'h01;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_total = err_total + 1;
      final_report;
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    for (i = 0; i < 4; i = i + 1) rd(i[3:0], 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wr(i[3:0], 8'hff);
      rd(i[3:0], i[0] ? 8'h3f : 8'hff);
    end
    wr(4'h9, 8'h5a);
    rd(4'h9, 8'h00);
    for (i = 0; i < 14; i = i + 1) begin
      cfg(14'h0001 << i, 14'h0000);
      want <= ~(14'h0001 << i);
      idle;
      chk("off", 8'h00, {7'h00, riseEvent});
      want <= 14'h0001 << i;
      idle;
      chk("level", 8'h01, {7'h00, riseEvent});
      cfg(14'h3fff, 14'h0001 << i);
      idle;
      chk("mode", 8'h00, {7'h00, riseImmediate});
      want <= 14'h0000;
    end
    for (d = 8'h00; d < 8'h06; d = d + 8'h03) begin
      wr(4'h4, d);
      cfg(14'h0001, 14'h0000);
      want <= 14'h0001;
      cnt(1'b0, c0);
      want <= 14'h0000;
      cfg(14'h0001, 14'h0001);
      want <= 14'h0001;
      cnt(1'b1, c1);
      chk("delay", c0 + d + 8'h01, c1);
      want <= 14'h0000;
    end
    cfg(14'h0000, 14'h3fff);
    idle;
    want <= 14'h3fff;
    cnt(1'b1, c1);
    chk("dis", 8'h28, c1);
    rd(4'h5, 8'h00);
    rd(4'h4, 8'h03);
    final_report;
  end
endmodule // rise_event_qualifier_bench
